// ===== frp_defines.vh
// constants for the read-parameter, software-reset and parameter-area command logic
// assumes a 10 MHz system clock and a serial clock far slower, sampled as a plain input
// What this block does
// R01 - in quad-peripheral mode, set-read-parameters sets dummy count and wrap length
// R02 - set-read-parameters is refused in standard SPI mode; SPI dummy counts fixed
// R03 - power-up or reset defaults: wrap length 8 bytes, dummy count 4
// R04 - dummy field codes 00 and 01 give 4 clocks, code 10 gives 6
// R05 - wrap field codes 00..11 select 8, 16, 32, 64 bytes
// R06 - accepted reset aborts any operation in progress and restores power-on state
// R07 - reset clears volatile status, write latch, suspend, continuous read, parameters, wrap
// R08 - reset-enable and reset are accepted in SPI and quad-peripheral mode
// R09 - reset acts only right after reset-enable; any other command disarms
// R10 - reset takes about 30 us, commands ignored meanwhile
// R11 - host should check busy and suspend before sending the reset pair
// R12 - parameter area is 2048 read-only bytes, unused bytes read FFh
// R13 - area read: opcode, 24-bit address, 8 dummy clocks, then data
// R14 - area bytes shift out from the address, changing on falling serial clock
// R15 - area read ends when chip select rises, at any point
// R16 - signature at 00h..03h, revision at 04h/05h, header count 06h, FFh at 07h
// R17 - first header at 08h: id 00h, rev 1.6, length 10h, pointer 30h
// R18 - second header at 10h: maker id, rev 1.0, length 02h, pointer 80h
// R19 - device starts in standard SPI mode after power-up
// R20 - set-read-parameters carries one byte: dummy bits 5:4, wrap bits 1:0; 11 reserved
`ifndef FRP_DEFINES_VH
`define FRP_DEFINES_VH
`define FRP_OP_SET_PARAM   8'hC0
`define FRP_OP_RST_EN      8'h66
`define FRP_OP_RST         8'h99
`define FRP_OP_READ_AREA   8'h5A
`define FRP_OP_QUAD_ON     8'h38
`define FRP_OP_QUAD_OFF    8'hFF
`define FRP_DUMMY_LO       3'h4
`define FRP_DUMMY_HI       3'h6
`define FRP_DUM_FIELD_HI   5
`define FRP_DUM_FIELD_LO   4
`define FRP_WRAP_FIELD_HI  1
`define FRP_WRAP_FIELD_LO  0
`define FRP_DUM_CODE_HI    2'h2
`define FRP_DUM_CODE_RSVD  2'h3
`define FRP_WRAP_DEFAULT   2'h0
`define FRP_DUM_DEFAULT    2'h0
`define FRP_AREA_AW        11
`define FRP_ERASED         8'hFF
`define FRP_AREA_DUMMY     4'h8
`define FRP_ADDR_BITS      5'h18
`define FRP_BYTE_BITS      3'h7
`define FRP_T_RST_NS       30000
`define FRP_CLK_NS         100
`define FRP_RST_CYCLES     ((`FRP_T_RST_NS) / (`FRP_CLK_NS))
`define FRP_BUF_DEPTH      2
`define FRP_MAKER_ID       8'h5C
`endif

// ===== frp_area_rom.v
// read-only parameter area: 2048 bytes, read data registered
// assumes read address held one cycle before data is wanted
`timescale 1ns/1ps
`include "frp_defines.vh"
module frp_area_rom (
  // clock
  input wire                      clk,
  // read port
  input wire [`FRP_AREA_AW-1:0]   addr,
  output reg [7:0]                rdata
);
  // maker id byte below is arbitrary
  // factory contents; all other locations erased
  always @(posedge clk) begin
    case (addr)
      11'h000: rdata <= 8'h53; // R16
      11'h001: rdata <= 8'h46;
      11'h002: rdata <= 8'h44;
      11'h003: rdata <= 8'h50;
      11'h004: rdata <= 8'h06;
      11'h005: rdata <= 8'h01;
      11'h006: rdata <= 8'h01;
      11'h008: rdata <= 8'h00; // R17
      11'h009: rdata <= 8'h06;
      11'h00A: rdata <= 8'h01;
      11'h00B: rdata <= 8'h10;
      11'h00C: rdata <= 8'h30;
      11'h00D: rdata <= 8'h00;
      11'h00E: rdata <= 8'h00;
      11'h010: rdata <= `FRP_MAKER_ID; // R18
      11'h011: rdata <= 8'h00;
      11'h012: rdata <= 8'h01;
      11'h013: rdata <= 8'h02;
      11'h014: rdata <= 8'h80;
      11'h015: rdata <= 8'h00;
      11'h016: rdata <= 8'h00;
      11'h017: rdata <= 8'h01;
      default: rdata <= `FRP_ERASED; // R12
    endcase
  end
endmodule

// ===== frp_buf2.v
// two-entry valid/ready buffer for bytes leaving the area
// assumes a single clock; source stalls on in_ready low
`timescale 1ns/1ps
`include "frp_defines.vh"
module frp_buf2 (
  // clock and reset
  input wire        clk,
  input wire        rst,
  input wire        flush,
  // fill side
  input wire        in_valid,
  output wire       in_ready,
  input wire [7:0]  in_data,
  // drain side
  output wire       out_valid,
  input wire        out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem_q [0:`FRP_BUF_DEPTH-1];
  reg       wp_q;
  reg       rp_q;
  reg [1:0] cnt_q;
  wire      push;
  wire      pop;
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // pointers and occupancy
  always @(posedge clk) begin
    if (rst | flush) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ===== frp_cmd.v
// command logic: set-read-parameters, reset pair, parameter-area read
// assumes sclk, cs_n and the data pins come from the host, outside clk's domain
`timescale 1ns/1ps
`include "frp_defines.vh"
module frp_cmd #(
  parameter RST_CYCLES = `FRP_RST_CYCLES
) (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // serial link from host
  input wire        cs_n,
  input wire        sclk,
  input wire [3:0]  io_in,
  output reg        so_out,
  output reg        so_oe,
  // mode and volatile state seen by other blocks
  input wire        quad_enable,
  output reg        quad_peripheral_mode,
  output reg [1:0]  dummy_cycle_field,
  output reg [1:0]  wrap_length_field,
  output wire [2:0] dummy_clocks,
  output wire [6:0] wrap_bytes,
  output reg        write_enable_latch,
  output reg        suspend_flag,
  output reg        cont_read_mode,
  output reg        reset_busy,
  output reg        abort_pulse
);
  localparam ST_OP    = 3'h0;
  localparam ST_PARAM = 3'h1;
  localparam ST_ADDR  = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_DATA  = 3'h4;
  localparam ST_SKIP  = 3'h5;

  // decode of dummy code to clocks
  function [2:0] dummy_of;
    input [1:0] code;
    begin
      dummy_of = (code == `FRP_DUM_CODE_HI) ? `FRP_DUMMY_HI : `FRP_DUMMY_LO; // R04
    end
  endfunction

  // wrap code to section size
  function [6:0] wrap_of;
    input [1:0] code;
    begin
      wrap_of = 7'h08 << code; // R05
    end
  endfunction

  assign dummy_clocks = dummy_of(dummy_cycle_field);
  assign wrap_bytes   = wrap_of(wrap_length_field);

  // two-flop synchronisers for pins
  reg        cs_s0_q, cs_s1_q, cs_s2_q;
  reg        ck_s0_q, ck_s1_q, ck_s2_q;
  reg [3:0]  io_s0_q, io_s1_q;
  always @(posedge clk) begin
    cs_s0_q <= cs_n;
    cs_s1_q <= cs_s0_q;
    cs_s2_q <= cs_s1_q;
    ck_s0_q <= sclk;
    ck_s1_q <= ck_s0_q;
    ck_s2_q <= ck_s1_q;
    io_s0_q <= io_in;
    io_s1_q <= io_s0_q;
  end
  wire sel     = ~cs_s1_q;
  wire rise    = ck_s1_q & ~ck_s2_q & sel;
  wire fall    = ~ck_s1_q & ck_s2_q & sel;
  wire cs_up   = cs_s1_q & ~cs_s2_q;

  reg [2:0]  st_q;
  reg [23:0] sh_q;
  reg [4:0]  cnt_q;
  reg        arm_q;
  reg [`FRP_AREA_AW-1:0] addr_q;
  reg [15:0] rcnt_q;
  reg [7:0]  obyte_q;
  reg [2:0]  obit_q;
  reg        ohave_q;
  reg        fetch_q;

  // shift-in: one bit per rising edge in SPI, nibble in quad mode
  wire [23:0] sh_d = quad_peripheral_mode ? {sh_q[19:0], io_s1_q} : {sh_q[22:0], io_s1_q[0]};
  wire [4:0]  step = quad_peripheral_mode ? 5'h4 : 5'h1;
  wire [4:0]  cnt_n = cnt_q + step;
  wire        byte_done = (cnt_n[3:0] == 4'h8) | cnt_n[4];

  // parameter-area memory and output buffer
  wire [7:0] rom_q;
  wire       buf_in_ready;
  wire       buf_out_valid;
  wire [7:0] buf_out_data;
  wire       buf_pop = (st_q == ST_DATA) & ~ohave_q & buf_out_valid;
  frp_area_rom u_rom (
    .clk   (clk),
    .addr  (addr_q),
    .rdata (rom_q)
  );
  frp_buf2 u_buf (
    .clk       (clk),
    .rst       (rst),
    .flush     (st_q != ST_DATA),
    .in_valid  (fetch_q),
    .in_ready  (buf_in_ready),
    .in_data   (rom_q),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  // main command sequencer
  always @(posedge clk) begin
    abort_pulse <= 1'b0;
    fetch_q     <= 1'b0;
    if (rst) begin
      st_q                 <= ST_OP;
      sh_q                 <= 24'h000000;
      cnt_q                <= 5'h00;
      arm_q                <= 1'b0;
      addr_q               <= {`FRP_AREA_AW{1'b0}};
      rcnt_q               <= 16'h0000;
      obyte_q              <= `FRP_ERASED;
      obit_q               <= 3'h0;
      ohave_q              <= 1'b0;
      so_out               <= 1'b0;
      so_oe                <= 1'b0;
      quad_peripheral_mode <= 1'b0; // R19
      dummy_cycle_field    <= `FRP_DUM_DEFAULT; // R03
      wrap_length_field    <= `FRP_WRAP_DEFAULT;
      write_enable_latch   <= 1'b0;
      suspend_flag         <= 1'b0;
      cont_read_mode       <= 1'b0;
      reset_busy           <= 1'b0;
    end else if (reset_busy) begin
      // hold off every command until recovery ends
      st_q   <= ST_OP; // R10
      cnt_q  <= 5'h00;
      so_oe  <= 1'b0;
      if (rcnt_q == 16'h0000)
        reset_busy <= 1'b0;
      else
        rcnt_q <= rcnt_q - 16'h0001;
    end else if (cs_up | ~sel) begin
      // chip select high ends any command
      st_q    <= ST_OP; // R15
      cnt_q   <= 5'h00;
      so_oe   <= 1'b0;
      ohave_q <= 1'b0;
    end else begin
      if (rise) begin
        sh_q <= sh_d;
        case (st_q)
          ST_OP: begin
            cnt_q <= byte_done ? 5'h00 : cnt_n;
            if (byte_done) begin
              arm_q <= 1'b0; // R09
              st_q  <= ST_SKIP;
              if (sh_d[7:0] == `FRP_OP_RST_EN) begin
                arm_q <= 1'b1; // R08
              end else if (sh_d[7:0] == `FRP_OP_RST && arm_q) begin
                // R06 R07
                abort_pulse          <= 1'b1;
                reset_busy           <= 1'b1;
                rcnt_q               <= RST_CYCLES[15:0] - 16'h0001;
                dummy_cycle_field    <= `FRP_DUM_DEFAULT;
                wrap_length_field    <= `FRP_WRAP_DEFAULT;
                write_enable_latch   <= 1'b0;
                suspend_flag         <= 1'b0;
                cont_read_mode       <= 1'b0;
                quad_peripheral_mode <= 1'b0;
              end else if (sh_d[7:0] == `FRP_OP_SET_PARAM && quad_peripheral_mode) begin
                st_q <= ST_PARAM; // R01 R02
              end else if (sh_d[7:0] == `FRP_OP_READ_AREA) begin
                st_q <= ST_ADDR; // R13
              end else if (sh_d[7:0] == `FRP_OP_QUAD_ON && quad_enable && !quad_peripheral_mode) begin
                quad_peripheral_mode <= 1'b1;
              end else if (sh_d[7:0] == `FRP_OP_QUAD_OFF && quad_peripheral_mode) begin
                quad_peripheral_mode <= 1'b0;
              end
            end
          end
          ST_PARAM: begin
            cnt_q <= byte_done ? 5'h00 : cnt_n;
            if (byte_done) begin
              st_q <= ST_SKIP;
              // reserved dummy code leaves setting unchanged
              if (sh_d[`FRP_DUM_FIELD_HI:`FRP_DUM_FIELD_LO] != `FRP_DUM_CODE_RSVD)
                dummy_cycle_field <= sh_d[`FRP_DUM_FIELD_HI:`FRP_DUM_FIELD_LO]; // R20
              wrap_length_field <= sh_d[`FRP_WRAP_FIELD_HI:`FRP_WRAP_FIELD_LO]; // R01
            end
          end
          ST_ADDR: begin
            cnt_q <= cnt_n;
            if (cnt_n >= `FRP_ADDR_BITS) begin
              addr_q <= sh_d[`FRP_AREA_AW-1:0];
              cnt_q  <= 5'h00;
              st_q   <= ST_DUMMY;
            end
          end
          ST_DUMMY: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q[3:0] == `FRP_AREA_DUMMY - 4'h1) begin
              st_q    <= ST_DATA; // R13
              fetch_q <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      // prefetch next area byte while buffer has room
      if (st_q == ST_DATA && buf_in_ready && !fetch_q && rise == 1'b0 && fall == 1'b0)
        fetch_q <= 1'b1;
      // step address only once the byte is taken, so the rom output catches up first
      if (st_q == ST_DATA && fetch_q)
        addr_q <= addr_q + {{(`FRP_AREA_AW-1){1'b0}}, 1'b1};
      if (buf_pop) begin
        obyte_q <= buf_out_data;
        ohave_q <= 1'b1;
        obit_q  <= `FRP_BYTE_BITS;
      end
      // drive one bit per falling edge, msb first
      if (fall && st_q == ST_DATA && ohave_q) begin
        so_oe  <= 1'b1; // R14
        so_out <= obyte_q[obit_q];
        if (obit_q == 3'h0)
          ohave_q <= 1'b0;
        obit_q <= obit_q - 3'h1;
      end
    end
  end
endmodule

// ===== frp_cmd_props.sv
// checker for frp_cmd: decodes, defaults, reset pair and recovery time
// sees only the ports of frp_cmd; bound at the foot of this file
`timescale 1ns/1ps
module frp_cmd_props #(
  parameter RST_CYCLES = 300
) (
  // clock and reset
  input wire       clk,
  input wire       rst,
  // link
  input wire       cs_n,
  input wire       so_oe,
  // volatile state
  input wire       quad_peripheral_mode,
  input wire [1:0] dummy_cycle_field,
  input wire [1:0] wrap_length_field,
  input wire [2:0] dummy_clocks,
  input wire [6:0] wrap_bytes,
  input wire       write_enable_latch,
  input wire       suspend_flag,
  input wire       cont_read_mode,
  input wire       reset_busy,
  input wire       abort_pulse
);
  reg [15:0] busy_q;
  // all volatile settings at their power-on values
  wire       clean = {dummy_cycle_field, wrap_length_field, quad_peripheral_mode,
                      write_enable_latch, suspend_flag, cont_read_mode} == 8'h00;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // length of the current recovery stretch
  always @(posedge clk) begin
    busy_q <= (rst || !reset_busy) ? 16'h0000 : busy_q + 16'h0001;
  end

  AST_DUMMY_DECODE: assert property (dummy_clocks == ((dummy_cycle_field == 2'h2) ? 3'h6 : 3'h4))
    else $error("dummy clock decode wrong");
  AST_WRAP_DECODE: assert property (wrap_bytes == (7'h08 << wrap_length_field))
    else $error("wrap length decode wrong");
  AST_DUMMY_RSVD: assert property (dummy_cycle_field != 2'h3)
    else $error("reserved dummy code stored");
  AST_POWER_DEFAULT: assert property ($fell(rst) |-> clean && !reset_busy && !abort_pulse)
    else $error("state not at default after reset");
  AST_ABORT_CLEARS: assert property (abort_pulse |-> ##[0:2] clean)
    else $error("soft reset left volatile state");
  AST_ABORT_BUSY: assert property (abort_pulse |-> ##[0:1] reset_busy)
    else $error("no recovery after soft reset");
  AST_ONE_PULSE: assert property (abort_pulse |=> !abort_pulse)
    else $error("abort pulse too long");
  AST_BUSY_LENGTH: assert property ($fell(reset_busy) && !$past(rst) |-> busy_q == RST_CYCLES)
    else $error("recovery length wrong");
  AST_NO_REARM_BUSY: assert property (reset_busy && $past(reset_busy) |-> !abort_pulse)
    else $error("reset taken during recovery");
  AST_PARAM_QUAD_ONLY: assert property ($changed({dummy_cycle_field, wrap_length_field})
    && !reset_busy && !abort_pulse |-> $past(quad_peripheral_mode))
    else $error("read parameters changed outside quad mode");
  AST_OE_RELEASE: assert property (cs_n [*6] |-> !so_oe)
    else $error("output driven after deselect");
endmodule

bind frp_cmd frp_cmd_props #(.RST_CYCLES(RST_CYCLES)) u_frp_cmd_props (
  .clk, .rst, .cs_n, .so_oe, .quad_peripheral_mode, .dummy_cycle_field, .wrap_length_field,
  .dummy_clocks, .wrap_bytes, .write_enable_latch, .suspend_flag, .cont_read_mode,
  .reset_busy, .abort_pulse
);

// ===== frp_host.sv
// host controller model: mode 0 serial link, clock idle low between frames
// assumes clk is the bench clock; serial clock runs at clk/8
`timescale 1ns/1ps
module frp_host (
  // pacing clock
  input wire       clk,
  // serial link
  input wire       so_out,
  input wire       so_oe,
  output reg       cs_n,
  output reg       sclk,
  output reg [3:0] io_in
);
  reg       quad;
  reg [7:0] rd [0:23];

  // idle link at time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_in = 4'hA;
    quad = 1'b0;
  end

  // half a serial clock period
  task half;
    begin
      repeat (4) @(negedge clk);
    end
  endtask

  // one serial clock; read just before the falling edge
  task unit(input [3:0] d, output r);
    begin
      io_in = d;
      half;
      sclk = 1'b1;
      half;
      r = so_oe ? so_out : ~so_out; // released line shows the opposite level
      sclk = 1'b0;
    end
  endtask

  // one byte, msb first; unused lines toggle
  task put(input [7:0] b);
    reg     r;
    integer i;
    begin
      if (quad) begin
        unit(b[7:4], r);
        unit(b[3:0], r);
      end else begin
        for (i = 7; i >= 0; i = i - 1)
          unit({~io_in[3:1], b[i]}, r);
      end
    end
  endtask

  // one byte read, msb first
  task get(output [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        unit(~io_in, b[i]);
    end
  endtask

  task start;
    begin
      @(negedge clk);
      cs_n = 1'b0;
      half;
    end
  endtask

  // deselect ends any command
  task stop;
    begin
      half;
      cs_n = 1'b1;
      io_in = ~io_in;
      repeat (8) @(negedge clk);
    end
  endtask

  // one frame with an optional parameter byte
  task cmd(input [7:0] op, input has_p, input [7:0] p);
    begin
      start;
      put(op);
      if (has_p)
        put(p);
      stop;
    end
  endtask

  // area read left open for the caller to end
  task area(input [23:0] a, input integer n);
    reg     r;
    integer k;
    begin
      start;
      put(8'h5A);
      put(a[23:16]);
      put(a[15:8]);
      put(a[7:0]);
      repeat (8) unit(~io_in, r);
      for (k = 0; k < n; k = k + 1)
        get(rd[k]);
    end
  endtask
endmodule

// ===== test_flash_read_param_reset_sfdp.sv
// self-checking bench for frp_cmd driven through the host model
// assumes frp_host paces the link from clk
`timescale 1ns/1ps
module test_flash_read_param_reset_sfdp;
  localparam RST_N = 100;
  localparam [7:0] MAKER_ID = 8'h5C; // arbitrary value
  localparam [191:0] HDR = {32'h53464450, 32'h060101FF, 32'h00060110, 32'h300000FF,
                            MAKER_ID, 24'h000102, 32'h80000001};
  reg        clk, rst, quad_enable;
  wire       cs_n, sclk, so_out, so_oe, quad_peripheral_mode, reset_busy, abort_pulse;
  wire       write_enable_latch, suspend_flag, cont_read_mode;
  wire [3:0] io_in;
  wire [1:0] dummy_cycle_field, wrap_length_field;
  wire [2:0] dummy_clocks;
  wire [6:0] wrap_bytes;
  integer    num_errors, n_tests, cycles, n_abort, i;
  reg [17:0] rows [0:4];

  frp_cmd #(.RST_CYCLES(RST_N)) u_frp_cmd (
    .clk, .rst, .cs_n, .sclk, .io_in, .so_out, .so_oe, .quad_enable, .quad_peripheral_mode,
    .dummy_cycle_field, .wrap_length_field, .dummy_clocks, .wrap_bytes, .write_enable_latch,
    .suspend_flag, .cont_read_mode, .reset_busy, .abort_pulse
  );
  frp_host u_frp_host (.clk, .so_out, .so_oe, .cs_n, .sclk, .io_in);

  always #50 clk = ~clk;

  // abort count and run limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (abort_pulse === 1'b1)
      n_abort <= n_abort + 1;
    if (cycles == 10000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end

  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task st(input [2:0] d, input [6:0] w, input q);
    begin
      chk("dummy", {5'h00, d}, {5'h00, dummy_clocks});
      chk("wrap", {1'b0, w}, {1'b0, wrap_bytes});
      chk("quad", {7'h00, q}, {7'h00, quad_peripheral_mode});
    end
  endtask

  // host waits out recovery
  task idle;
    integer k;
    begin
      for (k = 0; k < 400 && reset_busy !== 1'b0; k = k + 1)
        @(negedge clk);
    end
  endtask

  task finish_test;
    begin
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // parameter byte, dummy clocks, wrap bytes
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    quad_enable = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    n_abort = 0;
    rows[0] = {8'h11, 3'h4, 7'h10};
    rows[1] = {8'h22, 3'h6, 7'h20};
    rows[2] = {8'h33, 3'h6, 7'h40};
    rows[3] = {8'h03, 3'h4, 7'h40};
    rows[4] = {8'h20, 3'h6, 7'h08};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    st(3'h4, 7'h08, 1'b0);
    u_frp_host.cmd(8'hC0, 1'b1, 8'h22);
    st(3'h4, 7'h08, 1'b0);
    u_frp_host.cmd(8'h38, 1'b0, 8'h00);
    st(3'h4, 7'h08, 1'b0);
    quad_enable = 1'b1;
    u_frp_host.cmd(8'h38, 1'b0, 8'h00);
    u_frp_host.quad = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      u_frp_host.cmd(8'hC0, 1'b1, rows[i][17:10]);
      st(rows[i][9:7], rows[i][6:0], 1'b1);
    end
    u_frp_host.cmd(8'hFF, 1'b0, 8'h00);
    u_frp_host.quad = 1'b0;
    st(3'h6, 7'h08, 1'b0);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    st(3'h4, 7'h08, 1'b0);
    u_frp_host.cmd(8'h38, 1'b0, 8'h00);
    u_frp_host.quad = 1'b1;
    u_frp_host.cmd(8'h66, 1'b0, 8'h00);
    u_frp_host.cmd(8'hC0, 1'b1, 8'h21);
    u_frp_host.cmd(8'h99, 1'b0, 8'h00);
    st(3'h6, 7'h10, 1'b1);
    chk("aborts", 8'h00, n_abort[7:0]);
    u_frp_host.cmd(8'h66, 1'b0, 8'h00);
    u_frp_host.cmd(8'h99, 1'b0, 8'h00);
    u_frp_host.quad = 1'b0;
    chk("busy", 8'h01, {7'h00, reset_busy});
    u_frp_host.cmd(8'h66, 1'b0, 8'h00);
    idle;
    u_frp_host.cmd(8'h99, 1'b0, 8'h00);
    chk("aborts", 8'h01, n_abort[7:0]);
    st(3'h4, 7'h08, 1'b0);
    chk("volatile", 8'h00, {5'h00, write_enable_latch, suspend_flag, cont_read_mode});
    u_frp_host.cmd(8'h66, 1'b0, 8'h00);
    u_frp_host.cmd(8'h99, 1'b0, 8'h00);
    chk("aborts", 8'h02, n_abort[7:0]);
    idle;
    u_frp_host.area(24'h000000, 24);
    for (i = 0; i < 24; i = i + 1)
      chk("area", HDR[191 - 8 * i -: 8], u_frp_host.rd[i]);
    chk("drive", 8'h01, {7'h00, so_oe});
    u_frp_host.stop;
    chk("drive", 8'h00, {7'h00, so_oe});
    u_frp_host.area(24'hFF07FE, 3);
    for (i = 0; i < 3; i = i + 1)
      chk("area", (i < 2) ? 8'hFF : 8'h53, u_frp_host.rd[i]);
    u_frp_host.stop;
    finish_test;
  end
endmodule
